// *** rtl/wd_reset_flag_pkg.sv ***
// Shared constants for the watchdog with reset-cause flags.
package wd_reset_flag_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite slave)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h60;
  localparam logic [7:0] ADDR_RESET_CAUSE_STATUS = 8'h64;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Watchdog control field positions
  // ----------------------------------------------------------------
  localparam int CTL_IRQ_FLAG = 7;
  localparam int CTL_IRQ_EN = 6;
  localparam int CTL_PERIOD_HI = 5;
  localparam int CTL_CHANGE_EN = 4;
  localparam int CTL_RESET_EN = 3;
  localparam int CTL_PERIOD_LO_MSB = 2;

  // ----------------------------------------------------------------
  // Reset-cause field positions
  // ----------------------------------------------------------------
  localparam int RC_SCAN = 4;
  localparam int RC_WD = 3;
  localparam int RC_BROWNOUT = 2;
  localparam int RC_PIN = 1;
  localparam int RC_POWERON = 0;
  localparam int RC_WIDTH = 5;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] PERIOD_RESET = 4'h0;
  localparam logic RESET_EN_RESET = 1'b0;
  localparam logic [RC_WIDTH-1:0] CAUSE_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Counts of cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
  localparam int CNT_W = 20;
  localparam logic [20:0] BASE_PERIOD_OSC_CYCLES = 21'h000800;
  localparam logic [3:0] PERIOD_CODE_MAX = 4'h9;

endpackage

// *** rtl/wd_reset_flag_counter.sv ***
// Watchdog period counter running on oscillator ticks.
`timescale 1ns/1ps

module wd_reset_flag_counter (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic oscTick,
  input wire logic clearCount,
  input wire logic countEnable,
  input wire logic [3:0] periodSel,
  output logic timeoutPulse
);

  typedef struct packed {
    logic [wd_reset_flag_pkg::CNT_W-1:0] count;
    logic timeout;
  } wd_reset_flag_cnt_state_t;

  wd_reset_flag_cnt_state_t q;
  wd_reset_flag_cnt_state_t d;

  // ----------------------------------------------------------------
  // Terminal count for a period code
  // ----------------------------------------------------------------
  // Reserved codes behave as the longest period, the safest reading
  function automatic logic [wd_reset_flag_pkg::CNT_W-1:0] lastCount(input logic [3:0] code);
    logic [3:0] c;
    logic [20:0] len;
    c = (code > wd_reset_flag_pkg::PERIOD_CODE_MAX) ? wd_reset_flag_pkg::PERIOD_CODE_MAX : code;
    len = wd_reset_flag_pkg::BASE_PERIOD_OSC_CYCLES << c;
    lastCount = len[wd_reset_flag_pkg::CNT_W-1:0] - 20'h00001;
  endfunction

  // Count ticks, fire one pulse on reaching the selected count
  always_comb begin
    d = q;
    d.timeout = 1'b0;
    if (clearCount || !countEnable) begin
      d.count = '0;
    end else if (oscTick) begin
      if (q.count >= lastCount(periodSel)) begin
        d.count = '0;
        d.timeout = 1'b1;
      end else begin
        d.count = q.count + 20'h00001;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign timeoutPulse = q.timeout;

endmodule // wd_reset_flag_counter

// *** rtl/wd_reset_flag_watchdog.sv ***
// Watchdog timer with reset-cause flags behind an AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module wd_reset_flag_watchdog (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wdOscClk,
  input wire logic poweronReset,
  input wire logic pinReset,
  input wire logic brownoutReset,
  input wire logic scanResetInstruction,
  input wire logic wd_always_on_fuse,
  input wire logic wdRestart,
  input wire logic globalIrqEnable,
  input wire logic irqVectorAck,
  output logic wdIrqRequest,
  output logic wdResetPulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Pin order in the synchroniser: 0 power-on, 1 pin, 2 brown-out,
  // 3 scan, 4 fuse, 5 oscillator
  typedef struct packed {
    logic [5:0] syncA;
    logic [5:0] syncB;
    logic oscPrev;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wLane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wd_irq_flag;
    logic wd_irq_enable;
    logic wd_reset_enable;
    logic [3:0] wd_period_select;
    logic [2:0] changeCount;
    logic [wd_reset_flag_pkg::RC_WIDTH-1:0] resetCause;
    logic irqReq;
    logic resetPulse;
  } wd_reset_flag_state_t;

  wd_reset_flag_state_t q;
  wd_reset_flag_state_t d;

  logic timeoutPulse;
  logic fuseOn;
  logic resetEnEff;
  logic irqEnEff;
  logic wdEnabled;
  logic changeOpen;
  logic anyResetSrc;
  logic oscTick;

  // ----------------------------------------------------------------
  // Address decode, shared by the read and the write path
  // ----------------------------------------------------------------
  function automatic logic [1:0] regSel(input logic [7:0] addr);
    if (addr == wd_reset_flag_pkg::ADDR_WATCHDOG_CONTROL) begin
      regSel = 2'h1;
    end else if (addr == wd_reset_flag_pkg::ADDR_RESET_CAUSE_STATUS) begin
      regSel = 2'h2;
    end else begin
      regSel = 2'h0;
    end
  endfunction

  // ----------------------------------------------------------------
  // Effective mode, from stored bits, fuse and watchdog reset flag
  // ----------------------------------------------------------------
  // The fuse and the flag override the stored bit, so a failing
  // program cannot talk its way out of reset mode
  assign fuseOn = q.syncB[4];
  assign resetEnEff = fuseOn | q.wd_reset_enable | q.resetCause[wd_reset_flag_pkg::RC_WD];
  assign irqEnEff = q.wd_irq_enable & ~fuseOn;
  assign wdEnabled = resetEnEff | irqEnEff;
  assign changeOpen = (q.changeCount != 3'h0);
  assign anyResetSrc = |q.syncB[3:0];
  assign oscTick = q.syncB[5] & ~q.oscPrev;

  // Period counter; period bits only matter while enabled
  wd_reset_flag_counter u_counter (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .oscTick(oscTick),
    .clearCount(wdRestart | q.resetPulse),
    .countEnable(wdEnabled),
    .periodSel(q.wd_period_select),
    .timeoutPulse(timeoutPulse)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] wv;
    logic doWrite;
    logic [1:0] wSel;
    logic doReset;
    logic setIrq;
    wv = q.wData;
    doWrite = 1'b0;
    wSel = 2'h0;
    doReset = 1'b0;
    setIrq = 1'b0;
    d = q;

    // Two-stage synchronisers; only the second stage is looked at
    d.syncA = {wdOscClk, wd_always_on_fuse, scanResetInstruction, brownoutReset,
               pinReset, poweronReset};
    d.syncB = q.syncA;
    d.oscPrev = q.syncB[5];

    // Write address and data are taken independently
    if (s_axi_awvalid && q.awready) begin
      d.awHeld = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.wHeld = 1'b1;
      d.wData = s_axi_wdata[7:0];
      d.wLane0 = s_axi_wstrb[0];
    end

    // Response once both halves are held and the last one is gone
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.awHeld && q.wHeld && !q.bvalid) begin
      wSel = regSel(q.awAddr);
      doWrite = q.wLane0;
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (wSel == 2'h0) ? wd_reset_flag_pkg::RESP_SLVERR : wd_reset_flag_pkg::RESP_OKAY;
    end
    d.awready = ~d.awHeld;
    d.wready = ~d.wHeld;

    // Read path; data captured at the address handshake
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = wd_reset_flag_pkg::RESP_OKAY;
      case (regSel(s_axi_araddr))
        2'h1: begin
          d.rdata = {24'h000000, q.wd_irq_flag, irqEnEff, q.wd_period_select[3],
                     changeOpen, resetEnEff, q.wd_period_select[2:0]};
        end
        2'h2: begin
          d.rdata = {27'h0000000, q.resetCause};
        end
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = wd_reset_flag_pkg::RESP_SLVERR;
        end
      endcase
    end
    d.arready = ~d.rvalid;

    // Change window runs down every cycle
    if (changeOpen) begin
      d.changeCount = q.changeCount - 3'h1;
    end

    // Control register write
    if (doWrite && wSel == 2'h1) begin
      d.wd_irq_enable = wv[wd_reset_flag_pkg::CTL_IRQ_EN];
      if (wv[wd_reset_flag_pkg::CTL_IRQ_FLAG]) begin
        d.wd_irq_flag = 1'b0;
      end
      if (changeOpen) begin
        // Open window: reset enable and period take the written values
        d.wd_reset_enable = wv[wd_reset_flag_pkg::CTL_RESET_EN];
        d.wd_period_select = {wv[wd_reset_flag_pkg::CTL_PERIOD_HI],
                              wv[wd_reset_flag_pkg::CTL_PERIOD_LO_MSB:0]};
        d.changeCount = 3'h0;
      end else begin
        // Closed window: reset enable may only be set, period kept
        d.wd_reset_enable = q.wd_reset_enable | wv[wd_reset_flag_pkg::CTL_RESET_EN];
      end
      if (wv[wd_reset_flag_pkg::CTL_CHANGE_EN] && wv[wd_reset_flag_pkg::CTL_RESET_EN]) begin
        d.changeCount = wd_reset_flag_pkg::CHANGE_WINDOW_CYCLES;
      end
    end

    // Cause flags: writing zero clears, writing one leaves alone
    if (doWrite && wSel == 2'h2) begin
      d.resetCause = q.resetCause & wv[wd_reset_flag_pkg::RC_WIDTH-1:0];
    end

    // Vector execution clears the flag; in combined mode also the enable
    if (irqVectorAck && q.wd_irq_flag) begin
      d.wd_irq_flag = 1'b0;
      if (resetEnEff) begin
        d.wd_irq_enable = 1'b0;
      end
    end

    // Time-out action by mode
    if (timeoutPulse && wdEnabled) begin
      if (!resetEnEff) begin
        setIrq = 1'b1;
      end else if (irqEnEff && !q.wd_irq_flag) begin
        setIrq = 1'b1;
      end else begin
        doReset = 1'b1;
      end
    end
    // Set beats a write or vector clear in the same cycle; a system reset below still clears it
    if (setIrq) begin
      d.wd_irq_flag = 1'b1;
    end

    // Power-on clears the others; sets still win
    if (q.syncB[0]) begin
      d.resetCause[wd_reset_flag_pkg::RC_SCAN:wd_reset_flag_pkg::RC_PIN] = 4'h0;
    end
    if (q.syncB[0]) begin
      d.resetCause[wd_reset_flag_pkg::RC_POWERON] = 1'b1;
    end
    if (q.syncB[1]) begin
      d.resetCause[wd_reset_flag_pkg::RC_PIN] = 1'b1;
    end
    if (q.syncB[2]) begin
      d.resetCause[wd_reset_flag_pkg::RC_BROWNOUT] = 1'b1;
    end
    if (q.syncB[3]) begin
      d.resetCause[wd_reset_flag_pkg::RC_SCAN] = 1'b1;
    end
    if (doReset) begin
      d.resetCause[wd_reset_flag_pkg::RC_WD] = 1'b1;
    end

    // One-cycle internal reset pulse
    d.resetPulse = doReset;

    // Any system reset returns the control register to its start values;
    // the cause flags survive every source but power-on, which is their whole purpose
    if (anyResetSrc || q.resetPulse) begin
      d.wd_irq_flag = 1'b0;
      d.wd_irq_enable = 1'b0;
      d.wd_reset_enable = wd_reset_flag_pkg::RESET_EN_RESET;
      d.wd_period_select = wd_reset_flag_pkg::PERIOD_RESET;
      d.changeCount = 3'h0;
    end

    // Interrupt request gated by global enable, enable and flag
    d.irqReq = globalIrqEnable & irqEnEff & q.wd_irq_flag;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign wdIrqRequest = q.irqReq;
  assign wdResetPulse = q.resetPulse;

endmodule // wd_reset_flag_watchdog

// *** sim/wd_reset_flag_monitor.sv ***
// Port-level assertions for the watchdog register block.
`timescale 1ns/1ps
module wd_reset_flag_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic wd_always_on_fuse,
  input wire logic globalIrqEnable,
  input wire logic irqVectorAck,
  input wire logic wdIrqRequest,
  input wire logic wdResetPulse
);
  logic [7:0] awAddrQ;
  logic [7:0] arAddrQ;
  logic mappedW;
  // Addresses of transfers in flight
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      awAddrQ <= 8'h00;
      arAddrQ <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awAddrQ <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) arAddrQ <= s_axi_araddr;
    end
  end
  // Only the two registers answer OKAY
  assign mappedW = (awAddrQ == wd_reset_flag_pkg::ADDR_WATCHDOG_CONTROL) ||
                   (awAddrQ == wd_reset_flag_pkg::ADDR_RESET_CAUSE_STATUS);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----
  // Checks
  // ----
  a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready) |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp ==
      (mappedW ? wd_reset_flag_pkg::RESP_OKAY : wd_reset_flag_pkg::RESP_SLVERR)) else $error("bad bresp");
  a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during answer");
  a_cause_top_zero: assert property ((s_axi_rvalid &&
      arAddrQ == wd_reset_flag_pkg::ADDR_RESET_CAUSE_STATUS) |-> s_axi_rdata[31:5] == 27'h0)
    else $error("cause upper bits set");
  a_pulse_single: assert property (wdResetPulse |=> !wdResetPulse)
    else $error("reset pulse too long");
  a_irq_gated: assert property (wdIrqRequest |-> $past(globalIrqEnable))
    else $error("request without global enable");
  a_fuse_no_irq: assert property (wd_always_on_fuse [*5] |-> !wdIrqRequest)
    else $error("request with fuse set");
  a_ack_drops_irq: assert property ((irqVectorAck && wdIrqRequest) |=> ##1 !wdIrqRequest)
    else $error("request kept after vector");
endmodule // wd_reset_flag_monitor

bind wd_reset_flag_watchdog wd_reset_flag_monitor u_wd_reset_flag_monitor (.clk_sys, .rst_b, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .wd_always_on_fuse, .globalIrqEnable, .irqVectorAck, .wdIrqRequest,
  .wdResetPulse);

// *** sim/watchdog_with_reset_flags_tb.sv ***
// Self-checking bench for the watchdog register block.
`timescale 1ns/1ps
module watchdog_with_reset_flags_tb;
  localparam logic [7:0] CT = wd_reset_flag_pkg::ADDR_WATCHDOG_CONTROL;
  localparam logic [7:0] RC = wd_reset_flag_pkg::ADDR_RESET_CAUSE_STATUS;
  localparam logic [1:0] OK = wd_reset_flag_pkg::RESP_OKAY;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic wdIrqRequest, wdResetPulse;
  logic wd_always_on_fuse = 0, wdRestart = 0, globalIrqEnable = 0, irqVectorAck = 0;
  logic [3:0] srcs = 4'h0;
  logic [1:0] oscDiv = 2'h0;
  logic pulseSeen = 0;
  int errTotal = 0, testsRun = 0, n = 0;

  wd_reset_flag_watchdog u_wd_reset_flag_watchdog (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wdOscClk(oscDiv[1]), .poweronReset(srcs[0]), .pinReset(srcs[1]),
    .brownoutReset(srcs[2]), .scanResetInstruction(srcs[3]), .wd_always_on_fuse,
    .wdRestart, .globalIrqEnable, .irqVectorAck, .wdIrqRequest, .wdResetPulse);

  // Clock, and a fast free-running oscillator so time-outs stay short
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    oscDiv <= oscDiv + 2'h1;
    if (wdResetPulse) pulseSeen <= 1'b1;
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      errTotal++;
    end
  endtask
  task automatic stall(input string nm);
    $display("BAD %s expected event seen timeout", nm);
    errTotal++;
    print_verdict();
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) stall("write");
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) stall("read");
    chk(nm, e, s_axi_rdata);
    // Only the two mapped registers answer OKAY
    chk("rresp", {30'h0, (((a == CT) || (a == RC)) ? OK : wd_reset_flag_pkg::RESP_SLVERR)},
        {30'h0, s_axi_rresp});
  endtask
  task automatic src(input int i);
    srcs[i] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srcs[i] <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic kick();
    wdRestart <= 1'b1;
    @(posedge clk_sys);
    wdRestart <= 1'b0;
  endtask
  // Bounded wait, leaves the cycle count in n
  task automatic waitSig(ref logic s, input string nm);
    for (n = 0; n < 20000; n++) begin
      @(posedge clk_sys);
      if (s === 1'b1) break;
    end
    if (n == 20000) stall(nm);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(CT, 32'h0, "ctrl reset");
    rd(RC, 32'h0, "cause reset");
    wr(8'h70, 8'h00, wd_reset_flag_pkg::RESP_SLVERR);
    rd(8'h70, 32'h0, "unmapped read");
    // Cause flags: set, kept, cleared by zero and by power-on
    for (int i = 0; i < 4; i++) src(i);
    rd(RC, 32'h17, "cause all");
    wr(RC, 8'hff, OK);
    rd(RC, 32'h17, "cause w1");
    src(1);
    rd(RC, 32'h17, "poweron kept");
    wr(RC, 8'hfe, OK);
    rd(RC, 32'h16, "poweron clr");
    src(0);
    rd(RC, 32'h01, "poweron wipes");
    wr(RC, 8'h00, OK);
    rd(RC, 32'h00, "cause clr");
    // Protected fields
    wr(CT, 8'h08, OK);
    wr(CT, 8'h41, OK);
    rd(CT, 32'h48, "no window");
    wr(CT, 8'h18, OK);
    repeat (8) @(posedge clk_sys);
    wr(CT, 8'h01, OK);
    rd(CT, 32'h08, "window lapsed");
    kick();
    wr(CT, 8'h18, OK);
    wr(CT, 8'h25, OK);
    rd(CT, 32'h25, "split period");
    wr(CT, 8'h18, OK);
    wr(CT, 8'h40, OK);
    rd(CT, 32'h40, "irq mode");
    // Interrupt mode with the shortest period
    globalIrqEnable <= 1'b1;
    kick();
    waitSig(wdIrqRequest, "irq");
    chk("period", 32'h1, 32'(n >= 8180 && n <= 8215));
    kick();
    rd(CT, 32'hc0, "irq flag");
    globalIrqEnable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("gated", 32'h0, {31'h0, wdIrqRequest});
    wr(CT, 8'hc0, OK);
    rd(CT, 32'h40, "w1c");
    chk("no reset", 32'h0, {31'h0, pulseSeen});
    // Combined mode: vector, re-arm, then unserviced time-out
    wr(CT, 8'h48, OK);
    globalIrqEnable <= 1'b1;
    kick();
    waitSig(wdIrqRequest, "combined irq");
    chk("no reset yet", 32'h0, {31'h0, pulseSeen});
    irqVectorAck <= 1'b1;
    kick();
    irqVectorAck <= 1'b0;
    rd(CT, 32'h08, "vector");
    wr(CT, 8'h48, OK);
    waitSig(wdIrqRequest, "second irq");
    waitSig(pulseSeen, "wd reset");
    rd(RC, 32'h08, "wd flag");
    rd(CT, 32'h08, "forced en");
    wr(CT, 8'h18, OK);
    wr(CT, 8'h00, OK);
    rd(CT, 32'h08, "still forced");
    wr(RC, 8'h00, OK);
    wr(CT, 8'h18, OK);
    wr(CT, 8'h00, OK);
    rd(CT, 32'h00, "stopped");
    // Fuse locks reset mode
    wd_always_on_fuse <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(CT, 8'h40, OK);
    rd(CT, 32'h08, "fuse");
    print_verdict();
  end
endmodule // watchdog_with_reset_flags_tb
